// File: spc_map.vh
// Constants for the SDRAM pin control block: command codes, latencies, widths.
// Included by spc_pin_control.v and the other files except spc_mem.v; definitions only.
`ifndef SPC_MAP_VH
`define SPC_MAP_VH
// Command code {csN, rasN, casN, weN}
`define SPC_CMD_NOP 4'h7
`define SPC_CMD_ACTIVE 4'h3
`define SPC_CMD_READ 4'h5
`define SPC_CMD_WRITE 4'h4
`define SPC_CMD_BURST_TERM 4'h6
`define SPC_CMD_PRECHARGE 4'h2
`define SPC_CMD_REFRESH 4'h1
`define SPC_CMD_LOAD_MODE 4'h0
// Output mask latency in clocks
`define SPC_MASK_LATENCY 2
// Read data latency in clocks
`define SPC_READ_LATENCY 2
// Address bit that selects all banks or auto precharge
`define SPC_ADDR_BIT_TEN 10
// Configurations
`define SPC_CFG_X4 2'h0
`define SPC_CFG_X8 2'h1
`define SPC_CFG_X16 2'h2
// Power states
`define SPC_PWR_RUN 3'h0
`define SPC_PWR_PRE_PD 3'h1
`define SPC_PWR_ACT_PD 3'h2
`define SPC_PWR_SELF_REF 3'h3
`define SPC_PWR_SUSPEND 3'h4
// Reset values
`define SPC_RST_BURST_LEFT 4'h0
`endif

// File: spc_mem.v
// Small word memory with per-byte write enables and registered read data.
// Assumes a single clock; write and read may happen on the same edge.
`timescale 1ns/1ps
module spc_mem #(
  parameter AW = 6,
  parameter DW = 16
) (
  input wire clock, // System clock
  input wire [DW/8-1:0] wrByteEn, // Per-byte write enable
  input wire [AW-1:0] wrAddr, // Write address
  input wire [DW-1:0] wrData, // Write data
  input wire [AW-1:0] rdAddr, // Read address
  output reg [DW-1:0] rdData_q // Registered read data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  integer i;
  always @(posedge clock)
  begin
    for (i = 0; i < DW/8; i = i + 1)
      if (wrByteEn[i])
        mem[wrAddr][i*8 +: 8] <= wrData[i*8 +: 8];
    rdData_q <= mem[rdAddr];
  end
endmodule

// File: spc_pin_control.v
// SDRAM device-side pin control: command decode, clock enable states, data mask.
// Assumes the memory controller drives every input on the device clock.
`timescale 1ns/1ps
`include "spc_map.vh"
// How it works
// - All input pins are captured only on the rising clock edge.
// - Each active edge updates output data and, during a burst, advances the burst column.
// - Clock enable high lets edges act; low freezes the device.
// - Clock enable low picks power-down, self refresh or suspend from burst state, bank state and a refresh command.
// - In power-down or self refresh, clock enable is watched without clock gating.
// - In power-down or self refresh, input receivers except clock and clock enable are disabled.
// - Chip select low enables the command decoder, high disables it.
// - Chip select high masks commands but running bursts finish.
// - Data mask still works while chip select is high.
// - Command decoded from chip select, row, column strobes and write enable.
// - Mask high during write discards that cycle's data.
// - Mask high during read floats outputs two clocks later.
// - Low mask covers bits 7:0, high mask bits 15:8.
// - In narrow configurations one mask covers all; low mask unconnected.
// - Bank-select inputs name the bank for activate, read, write, precharge.
// - Precharge with address bit ten high closes all banks, else one.
// - Column width follows COLW; address bit ten selects auto precharge.
module spc_pin_control #(
  parameter CFG = `SPC_CFG_X16,
  parameter DW = 16,
  parameter COLW = 6,
  parameter BURST_LEN = 4
) (
  input wire clock, // System clock
  input wire rst, // Synchronous reset, active high
  input wire clockEnable, // Clock enable pin
  input wire chipSelectN, // Chip select, active low
  input wire rowStrobeN, // Row strobe, active low
  input wire colStrobeN, // Column strobe, active low
  input wire writeEnableN, // Write enable, active low
  input wire [1:0] bankSel, // Bank select
  input wire [11:0] addr, // Address, addr_bit_ten is bit 10
  input wire low_byte_mask, // Mask for bits 7:0
  input wire high_byte_mask, // Mask for bits 15:8, sole mask when narrow
  input wire [DW-1:0] dqIn, // Data pin input
  output reg [DW-1:0] dqOut_q, // Data pin output
  output reg [DW-1:0] dqOe_q, // Data output enable per bit, high drives
  output reg [3:0] bankOpen_q, // Row open per bank
  output reg [2:0] powerState_q, // Current clock enable state
  output reg receiversOn_q // Input receivers enabled
);
  // Pins pass two flops; clock enable has its own two-flop copy used for wake
  reg [DW+19:0] pinS1_q, pinS2_q;
  reg cke1_q, cke2_q;
  reg [1:0] burstBank_q;
  reg [COLW-1:0] burstCol_q;
  reg [3:0] burstLeft_q;
  reg burstIsWrite_q, autoPre_q;
  reg [`SPC_READ_LATENCY-1:0] rdValidPipe_q;
  reg [1:0] maskPipe1_q, maskPipe2_q;
  reg [DW-1:0] rdHold_q;
  reg [DW-1:0] wrDataDly_q;
  reg [1:0] wrMaskDly_q;
  wire [3:0] cmd;
  wire [1:0] sBank;
  wire [11:0] sAddr;
  wire sLowMask, sHighMask;
  wire [DW-1:0] sDq;
  wire [DW-1:0] memRd;
  wire active;
  wire lowPower;
  wire burstRun;
  wire [1:0] effMask;
  wire [DW/8-1:0] wrBe;
  wire [COLW-1:0] colStart;

  // Expand the byte masks to the bus width
  function [DW/8-1:0] laneMask;
    input [1:0] m;
    integer k;
    begin
      for (k = 0; k < DW/8; k = k + 1)
        laneMask[k] = (DW > 8) ? m[k] : m[1];
    end
  endfunction

  function [DW-1:0] bitMask;
    input [1:0] m;
    integer k;
    begin
      for (k = 0; k < DW; k = k + 1)
        bitMask[k] = (DW > 8) ? m[k/8] : m[1];
    end
  endfunction

  always @(posedge clock)
  begin
    pinS1_q <= {chipSelectN, rowStrobeN, colStrobeN, writeEnableN, bankSel, addr,
                low_byte_mask, high_byte_mask, dqIn};
    pinS2_q <= pinS1_q;
    cke1_q <= clockEnable;
    cke2_q <= cke1_q;
  end

  assign cmd = pinS2_q[DW+19:DW+16];
  assign sBank = pinS2_q[DW+15:DW+14];
  assign sAddr = pinS2_q[DW+13:DW+2];
  // Narrow parts ignore the low mask pin
  assign sLowMask = (CFG == `SPC_CFG_X16) ? pinS2_q[DW+1] : pinS2_q[DW];
  assign sHighMask = pinS2_q[DW];
  assign effMask = {sHighMask, sLowMask};
  assign sDq = pinS2_q[DW-1:0];

  assign lowPower = (powerState_q == `SPC_PWR_PRE_PD) || (powerState_q == `SPC_PWR_ACT_PD) ||
                    (powerState_q == `SPC_PWR_SELF_REF);
  // Wake uses the synchronised level regardless of the frozen command path
  assign active = cke2_q && (powerState_q == `SPC_PWR_RUN);
  assign burstRun = (burstLeft_q != `SPC_RST_BURST_LEFT);
  // Column narrower than the array uses low bits; bit ten reserved for auto precharge
  assign colStart = sAddr[COLW-1:0];
  assign wrBe = (active && burstRun && burstIsWrite_q) ? ~laneMask(wrMaskDly_q) : {DW/8{1'b0}};

  spc_mem #(
    .AW(COLW + 2),
    .DW(DW)
  ) uMem (
    .clock(clock),
    .wrByteEn(wrBe),
    .wrAddr({burstBank_q, burstCol_q}),
    .wrData(wrDataDly_q),
    .rdAddr({burstBank_q, burstCol_q}),
    .rdData_q(memRd)
  );

  // Power state choice follows bank and burst conditions
  always @(posedge clock)
  begin
    if (rst)
    begin
      powerState_q <= `SPC_PWR_RUN;
      receiversOn_q <= 1'b1;
    end
    else
    begin
      case (powerState_q)
        `SPC_PWR_RUN:
          if (!cke2_q)
          begin
            if (burstRun)
              powerState_q <= `SPC_PWR_SUSPEND;
            else if (bankOpen_q != 4'h0)
              powerState_q <= `SPC_PWR_ACT_PD;
            else if (cmd == `SPC_CMD_REFRESH)
              powerState_q <= `SPC_PWR_SELF_REF;
            else
              powerState_q <= `SPC_PWR_PRE_PD;
            receiversOn_q <= burstRun;
          end
        `SPC_PWR_PRE_PD, `SPC_PWR_ACT_PD, `SPC_PWR_SELF_REF:
          if (cke2_q)
          begin
            powerState_q <= `SPC_PWR_RUN;
            receiversOn_q <= 1'b1;
          end
        `SPC_PWR_SUSPEND:
          if (cke2_q)
            powerState_q <= `SPC_PWR_RUN;
        default:
          powerState_q <= `SPC_PWR_RUN;
      endcase
    end
  end

  // Command decode and burst engine
  always @(posedge clock)
  begin
    if (rst)
    begin
      bankOpen_q <= 4'h0;
      burstBank_q <= 2'h0;
      burstCol_q <= {COLW{1'b0}};
      burstLeft_q <= `SPC_RST_BURST_LEFT;
      burstIsWrite_q <= 1'b0;
      autoPre_q <= 1'b0;
      wrDataDly_q <= {DW{1'b0}};
      wrMaskDly_q <= 2'h0;
    end
    else if (active)
    begin
      // Write data lag one edge, so the word taken with the command lands first
      wrDataDly_q <= sDq;
      wrMaskDly_q <= effMask;
      if (burstRun)
      begin
        burstCol_q <= burstCol_q + {{(COLW-1){1'b0}}, 1'b1};
        burstLeft_q <= burstLeft_q - 4'h1;
        if (burstLeft_q == 4'h1 && autoPre_q)
          bankOpen_q[burstBank_q] <= 1'b0;
      end
      // Commands only when selected; running bursts continue either way
      if (cmd[3] == 1'b0)
      begin
        case (cmd)
          `SPC_CMD_ACTIVE:
            bankOpen_q[sBank] <= 1'b1;
          `SPC_CMD_READ, `SPC_CMD_WRITE:
          begin
            burstBank_q <= sBank;
            burstCol_q <= colStart;
            burstLeft_q <= BURST_LEN[3:0];
            burstIsWrite_q <= (cmd == `SPC_CMD_WRITE);
            autoPre_q <= sAddr[`SPC_ADDR_BIT_TEN];
          end
          `SPC_CMD_BURST_TERM:
            burstLeft_q <= `SPC_RST_BURST_LEFT;
          `SPC_CMD_PRECHARGE:
            if (sAddr[`SPC_ADDR_BIT_TEN])
              bankOpen_q <= 4'h0;
            else
              bankOpen_q[sBank] <= 1'b0;
          `SPC_CMD_NOP: ;
          default: ;
        endcase
      end
    end
  end

  // Read data and two-clock mask pipelines, independent of chip select
  always @(posedge clock)
  begin
    if (rst)
    begin
      rdValidPipe_q <= {`SPC_READ_LATENCY{1'b0}};
      maskPipe1_q <= 2'h0;
      maskPipe2_q <= 2'h0;
      dqOut_q <= {DW{1'b0}};
      rdHold_q <= {DW{1'b0}};
      dqOe_q <= {DW{1'b0}};
    end
    else if (powerState_q == `SPC_PWR_RUN || powerState_q == `SPC_PWR_SUSPEND)
    begin
      if (active)
      begin
        rdValidPipe_q <= {rdValidPipe_q[`SPC_READ_LATENCY-2:0], burstRun && !burstIsWrite_q};
        maskPipe1_q <= effMask;
        maskPipe2_q <= maskPipe1_q;
        // Extra stage keeps the data in step with the drive enable pipe
        rdHold_q <= memRd;
        dqOut_q <= rdHold_q;
        dqOe_q <= rdValidPipe_q[`SPC_READ_LATENCY-1] ? ~bitMask(maskPipe2_q) : {DW{1'b0}};
      end
    end
    else
      dqOe_q <= {DW{1'b0}};
  end
endmodule

// File: spc_pin_control_sva.sv
// Checker: power, mask and reset relations of spc_pin_control.
// Sees only the block's ports; bound after the module.
`timescale 1ns/1ps
`include "spc_map.vh"
module spc_pin_control_sva #(parameter DW = 16) (
  input wire clock, // clock
  input wire rst, // reset
  input wire clockEnable, // enable
  input wire low_byte_mask, // low mask
  input wire high_byte_mask, // high mask
  input wire [DW-1:0] dqOut_q, // data
  input wire [DW-1:0] dqOe_q, // drive
  input wire [3:0] bankOpen_q, // rows
  input wire [2:0] powerState_q, // state
  input wire receiversOn_q // receivers
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  wire lowPower = powerState_q inside {`SPC_PWR_PRE_PD, `SPC_PWR_ACT_PD, `SPC_PWR_SELF_REF};
  a_reset_values: assert property (disable iff (1'b0) rst |=> powerState_q == `SPC_PWR_RUN
    && receiversOn_q && bankOpen_q == 4'h0 && dqOe_q == '0) else $error("bad reset state");
  a_rx_off_low: assert property (lowPower [*2] |-> !receiversOn_q) else $error("rx on");
  a_wake_run: assert property (clockEnable [*3] |-> ##[0:8] powerState_q == `SPC_PWR_RUN)
    else $error("no wake");
  a_idle_banks: assert property (powerState_q inside {`SPC_PWR_PRE_PD, `SPC_PWR_SELF_REF}
    |-> bankOpen_q == 4'h0) else $error("row open in idle state");
  a_open_row_apd: assert property (powerState_q == `SPC_PWR_ACT_PD |-> bankOpen_q != 4'h0)
    else $error("no row open");
  a_suspend_hold: assert property (powerState_q == `SPC_PWR_SUSPEND && $past(powerState_q) == `SPC_PWR_SUSPEND
    |-> $stable(dqOut_q) && $stable(bankOpen_q)) else $error("moved in suspend");
  a_high_mask_z: assert property (high_byte_mask && clockEnable |-> ##[1:6] dqOe_q[DW-1:DW/2] == '0)
    else $error("high byte driven");
  a_low_mask_z: assert property (low_byte_mask && clockEnable |-> ##[1:6] dqOe_q[7:0] == 8'h00)
    else $error("low byte driven");
  a_byte_enable: assert property (dqOe_q[7:0] inside {8'h00, 8'hFF}) else $error("split byte");
  cover property (powerState_q == `SPC_PWR_SELF_REF);
  cover property (powerState_q == `SPC_PWR_SUSPEND);
  cover property (dqOe_q[7:0] == 8'h00 && dqOe_q[DW-1:8] != '0);
endmodule
bind spc_pin_control spc_pin_control_sva #(.DW(DW)) chk (.clock, .rst, .clockEnable, .low_byte_mask,
  .high_byte_mask, .dqOut_q, .dqOe_q, .bankOpen_q, .powerState_q, .receiversOn_q);

// File: spc_ctrl_model.sv
// Memory controller model driving the device pins.
// Assumes the device samples on the rising clock edge.
`timescale 1ns/1ps
`include "spc_map.vh"
module spc_ctrl_model (
  input wire clock, // clock
  output reg clockEnable, // enable
  output reg chipSelectN, // select
  output reg rowStrobeN, // row
  output reg colStrobeN, // column
  output reg writeEnableN, // write
  output reg [1:0] bankSel, // bank
  output reg [11:0] addr, // address
  output reg low_byte_mask, // low mask
  output reg high_byte_mask, // high mask
  output reg [15:0] dq // data
);
  initial
  begin
    clockEnable = 1'b1;
    {chipSelectN, rowStrobeN, colStrobeN, writeEnableN} = `SPC_CMD_NOP;
    {bankSel, addr, low_byte_mask, high_byte_mask, dq} = 32'h0;
  end
  task issue(input [3:0] c, input [1:0] b, input [11:0] a, input [15:0] d, input [1:0] m);
  begin
    @(posedge clock);
    #5;
    {chipSelectN, rowStrobeN, colStrobeN, writeEnableN} = c;
    bankSel = b;
    addr = a;
    dq = d;
    {high_byte_mask, low_byte_mask} = m;
  end
  endtask
  task idle(input integer n);
    integer j;
  begin
    // Inverted data: a released bus must not look stable
    for (j = 0; j < n; j = j + 1)
      issue(`SPC_CMD_NOP, 2'h0, 12'h000, ~dq, 2'h0);
  end
  endtask
endmodule

// File: spc_pin_control_test.sv
// Bench for spc_pin_control: command rows, then data, mask and power cases.
// Assumes spc_ctrl_model drives the pins 5 ns after each edge.
`timescale 1ns/1ps
`include "spc_map.vh"
module spc_pin_control_test;
  reg clock = 1'b0;
  reg rst = 1'b1;
  wire clockEnable, chipSelectN, rowStrobeN, colStrobeN, writeEnableN, low_byte_mask, high_byte_mask;
  wire [1:0] bankSel;
  wire [11:0] addr;
  wire [15:0] dqIn, dqOut_q, dqOe_q;
  wire [3:0] bankOpen_q;
  wire [2:0] powerState_q;
  wire receiversOn_q;
  integer n_mismatch = 0, checks = 0, cyc = 0, i, k;
  reg [21:0] row [0:6];
  reg [15:0] got [0:3];
  spc_pin_control uut (.clock, .rst, .clockEnable, .chipSelectN, .rowStrobeN, .colStrobeN, .writeEnableN,
    .bankSel, .addr, .low_byte_mask, .high_byte_mask, .dqIn, .dqOut_q, .dqOe_q, .bankOpen_q, .powerState_q,
    .receiversOn_q);
  spc_ctrl_model ctl (.clock, .clockEnable, .chipSelectN, .rowStrobeN, .colStrobeN, .writeEnableN, .bankSel,
    .addr, .low_byte_mask, .high_byte_mask, .dq(dqIn));
  initial
  begin
    forever #50 clock = ~clock;
  end
  task close_out;
  begin
    if (n_mismatch == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  task check(input string what, input [15:0] seen, input [15:0] want);
  begin
    checks = checks + 1;
    if (seen !== want)
    begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  end
  endtask
  task pwr(input [2:0] want);
  begin
    ctl.idle(6);
    check("powerState", {13'h0, powerState_q}, {13'h0, want});
    check("receiversOn", {15'h0, receiversOn_q}, {15'h0, want == `SPC_PWR_SUSPEND});
    ctl.clockEnable = 1'b1;
    ctl.idle(8);
    check("powerState", {13'h0, powerState_q}, 16'h0000);
  end
  endtask
  // Tests need about 180 cycles
  always @(posedge clock)
  begin
    cyc = cyc + 1;
    if (cyc == 2000)
    begin
      n_mismatch = n_mismatch + 1;
      close_out;
    end
  end
  initial
  begin
    row[0] = {`SPC_CMD_ACTIVE, 2'h0, 12'hFFF, 4'h1};
    row[1] = {`SPC_CMD_ACTIVE, 2'h2, 12'h000, 4'h5};
    row[2] = {`SPC_CMD_PRECHARGE, 2'h0, 12'hBFF, 4'h4};
    row[3] = {`SPC_CMD_ACTIVE, 2'h1, 12'h5A5, 4'h6};
    row[4] = {`SPC_CMD_PRECHARGE, 2'h0, 12'h400, 4'h0};
    row[5] = {4'hB, 2'h3, 12'h000, 4'h0}; // Active while deselected
    row[6] = {`SPC_CMD_NOP, 2'h1, 12'h000, 4'h0};
    repeat (20) @(posedge clock);
    check("reset", {bankOpen_q, 5'h0, receiversOn_q, powerState_q, dqOe_q[2:0]}, 16'h0040);
    #5 rst = 1'b0;
    for (i = 0; i < 7; i = i + 1)
    begin
      ctl.issue(row[i][21:18], row[i][17:16], row[i][15:4], 16'h0000, 2'h0);
      ctl.idle(5);
      check("bankOpen", {12'h0, bankOpen_q}, {12'h0, row[i][3:0]});
    end
    ctl.issue(`SPC_CMD_ACTIVE, 2'h0, 12'h000, 16'h0000, 2'h0);
    ctl.idle(5);
    for (k = 0; k < 2; k = k + 1)
    begin
      ctl.issue(`SPC_CMD_WRITE, 2'h0, 12'h02A, k ? 16'hBBBB : 16'hAAAA, 2'h0);
      for (i = 1; i < 4; i = i + 1)
        ctl.issue(k ? 4'hF : `SPC_CMD_NOP, 2'h0, 12'h000, k ? 16'hBBBB : 16'hAAAA, {k == 1 && i == 1, 1'b0});
      ctl.idle(4);
    end
    ctl.issue(`SPC_CMD_READ, 2'h0, 12'h02A, 16'h0000, 2'h0);
    k = 0;
    for (i = 0; i < 10; i = i + 1)
    begin
      ctl.idle(1);
      if (dqOe_q[0] === 1'b1 && k < 4)
      begin
        got[k] = dqOut_q;
        k = k + 1;
      end
    end
    check("words", k[15:0], 16'h0004);
    for (i = 0; i < 4; i = i + 1)
      check("word", got[i], i == 1 ? 16'hAABB : 16'hBBBB);
    ctl.issue(`SPC_CMD_READ, 2'h0, 12'h02A, 16'h0000, 2'h0);
    ctl.issue(4'hF, 2'h0, 12'h000, 16'h0000, 2'h1);
    k = 0;
    for (i = 0; i < 10; i = i + 1)
    begin
      ctl.idle(1);
      if (dqOe_q === 16'hFF00)
        k = k + 1;
    end
    check("maskedReads", k[15:0], 16'h0001);
    ctl.clockEnable = 1'b0;
    pwr(`SPC_PWR_ACT_PD);
    ctl.issue(`SPC_CMD_READ, 2'h0, 12'h000, 16'h0000, 2'h0);
    ctl.idle(2);
    ctl.clockEnable = 1'b0;
    pwr(`SPC_PWR_SUSPEND);
    ctl.issue(`SPC_CMD_PRECHARGE, 2'h0, 12'h400, 16'h0000, 2'h0);
    ctl.idle(5);
    ctl.clockEnable = 1'b0;
    pwr(`SPC_PWR_PRE_PD);
    ctl.issue(`SPC_CMD_REFRESH, 2'h0, 12'h000, 16'h0000, 2'h0);
    ctl.clockEnable = 1'b0;
    pwr(`SPC_PWR_SELF_REF);
    // Reset in mid-run must close rows and leave the decoder usable
    ctl.issue(`SPC_CMD_ACTIVE, 2'h3, 12'h000, 16'h0000, 2'h0);
    ctl.idle(3);
    check("bankOpen", {12'h0, bankOpen_q}, 16'h0008);
    rst = 1'b1;
    ctl.idle(2);
    check("reset", {bankOpen_q, 5'h0, receiversOn_q, powerState_q, dqOe_q[2:0]}, 16'h0040);
    rst = 1'b0;
    ctl.issue(`SPC_CMD_ACTIVE, 2'h1, 12'h000, 16'h0000, 2'h0);
    ctl.idle(3);
    check("bankOpen", {12'h0, bankOpen_q}, 16'h0002);
    close_out;
  end
endmodule
